// *** verilog/word_move_pkg.sv ***
// Constants and types for the word-move opcode decoder
package word_move_pkg;
    localparam logic [7:0] LEAD_ABS = 8'h3e;
    localparam logic [7:0] LEAD_SHORT = 8'h07;
    localparam logic [7:0] LEAD_ALT_PREFIX = 8'h3c;
    localparam logic [7:0] LEAD_INDIRECT = 8'h16;
    localparam logic [7:0] LEAD_DISP = 8'h06;
    localparam logic [7:0] LEAD_IMM_IDX = 8'h0a;
    localparam logic [7:0] LEAD_BASE_IDX = 8'h17;
    localparam logic [4:0] SUB_ST16 = 5'h09;
    localparam logic [4:0] SUB_LD24 = 5'h0a;
    localparam logic [4:0] SUB_ST24 = 5'h0b;
    localparam logic [7:0] SHORT_WORD_CODE = 8'h21;
    localparam logic [7:0] SHORT_LONG_CODE = 8'h31;
    localparam logic [3:0] LOW_NIB_WORD = 4'h1;
    localparam logic [7:0] BASE_IDX_CODE = 8'h01;
    localparam logic [2:0] PTR_STEP = 3'h2;
    localparam logic [3:0] MAX_INDIRECT = 4'h7;
    localparam logic [3:0] MAX_DISP = 4'h4;
    localparam logic [3:0] MAX_IMM_IDX = 4'h3;

    typedef enum logic [3:0] {
        OP_NONE, OP_ST_ABS16, OP_LD_ABS24, OP_ST_ABS24,
        OP_LD_SHORT_WORD, OP_LD_SHORT_LONG, OP_LD_INDIRECT,
        OP_LD_DISP, OP_LD_IMM_IDX, OP_LD_BASE_IDX
    } op_t;

    typedef enum logic [3:0] {
        PTR_NONE, PTR_ONE, PTR_TWO, PTR_THREE, PTR_FOUR, PTR_STACK,
        IDX_PAIR_TWO, IDX_BYTE, IDX_PAIR_THREE, IDX_BYTE_TWO
    } sel_t;

    typedef enum logic [1:0] {ADJ_NONE, ADJ_INC, ADJ_DEC} adj_t;

    typedef struct packed {
        op_t op;
        logic [2:0] reg_pair_field;
        sel_t base;
        sel_t index;
        adj_t adjust;
        logic [2:0] adjust_step;
        logic alt_area;
        logic [23:0] address;
        logic [7:0] offset;
    } decode_t;
endpackage : word_move_pkg

// *** verilog/word_move_opcode_decoder.sv ***
// Byte-serial decoder for the word-transfer instruction group
// Summary of operation
// - 3e then low bits 01001 stores a pair to absolute_16, low byte first.
// - 3e then low bits 01010 loads a pair from absolute_24, upper-low-middle.
// - 3e then low bits 01011 stores a pair to absolute_24, upper-low-middle.
// - In absolute forms byte two bits 7:5 are reg_pair_field, 4:0 sub-code.
// - 07 then 21 or 31 loads the accumulator via short pointer; 3c 07 prefix means alternate area.
// - 06 then nibble 0-4 selects the base of a one-byte displacement load.
// - 0a then nibble 0-3 selects the index of an immediate_offset_wide load, low-middle-upper.
`timescale 1ns/1ps
module word_move_opcode_decoder
    import word_move_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    output logic decode_valid,
    output decode_t decode,
    output logic undefined_instr
);
    typedef enum {
        S_LEAD, S_PREFIX2, S_SECOND, S_OPERAND, S_DONE, S_UNDEF
    } state_t;

    state_t state_r, state_nxt;
    logic [7:0] lead_r, lead_nxt;
    logic [1:0] left_r, left_nxt;
    logic [1:0] idx_r, idx_nxt;
    decode_t dec_r, dec_nxt;

    // Operand byte slot for the count of bytes already taken
    function automatic logic [4:0] slot(input op_t op, input logic [1:0] i);
        logic [4:0] r;
        r = 5'd24;
        case (op)
            OP_ST_ABS16: r = (i == 2'd0) ? 5'd0 : 5'd8;
            OP_LD_ABS24, OP_ST_ABS24:
                r = (i == 2'd0) ? 5'd16 :
                    (i == 2'd1) ? 5'd0 : 5'd8;
            OP_LD_IMM_IDX:
                r = (i == 2'd0) ? 5'd0 :
                    (i == 2'd1) ? 5'd8 : 5'd16;
            default: r = 5'd24;
        endcase
        return r;
    endfunction : slot

    always_comb begin
        logic [3:0] hi;
        logic [4:0] pos;
        hi = byte_data[7:4];
        pos = 5'd0;
        state_nxt = state_r;
        lead_nxt = lead_r;
        left_nxt = left_r;
        idx_nxt = idx_r;
        dec_nxt = dec_r;
        if (state_r == S_DONE || state_r == S_UNDEF) begin
            state_nxt = S_LEAD;
        end
        if (byte_valid) begin
            case (state_r)
                S_LEAD, S_DONE, S_UNDEF: begin
                    dec_nxt = '0;
                    lead_nxt = byte_data;
                    idx_nxt = 2'd0;
                    left_nxt = 2'd0;
                    case (byte_data)
                        LEAD_ABS, LEAD_SHORT, LEAD_INDIRECT, LEAD_DISP,
                        LEAD_IMM_IDX, LEAD_BASE_IDX: state_nxt = S_SECOND;
                        LEAD_ALT_PREFIX: state_nxt = S_PREFIX2;
                        default: state_nxt = S_UNDEF;
                    endcase
                end
                S_PREFIX2: begin
                    if (byte_data == LEAD_SHORT) begin
                        dec_nxt.alt_area = 1'b1;
                        lead_nxt = LEAD_SHORT;
                        state_nxt = S_SECOND;
                    end else begin
                        state_nxt = S_UNDEF;
                    end
                end
                S_SECOND: begin
                    state_nxt = S_UNDEF;
                    case (lead_r)
                        LEAD_ABS: begin
                            dec_nxt.reg_pair_field = byte_data[7:5];
                            case (byte_data[4:0])
                                SUB_ST16: begin
                                    dec_nxt.op = OP_ST_ABS16;
                                    left_nxt = 2'd2;
                                end
                                SUB_LD24: begin
                                    dec_nxt.op = OP_LD_ABS24;
                                    left_nxt = 2'd3;
                                end
                                SUB_ST24: begin
                                    dec_nxt.op = OP_ST_ABS24;
                                    left_nxt = 2'd3;
                                end
                                default: left_nxt = 2'd0;
                            endcase
                        end
                        LEAD_SHORT: begin
                            left_nxt = 2'd1;
                            if (byte_data == SHORT_WORD_CODE) begin
                                dec_nxt.op = OP_LD_SHORT_WORD;
                            end else if (byte_data == SHORT_LONG_CODE) begin
                                dec_nxt.op = OP_LD_SHORT_LONG;
                            end else begin
                                left_nxt = 2'd0;
                            end
                        end
                        LEAD_INDIRECT: begin
                            if (byte_data[3:0] == LOW_NIB_WORD &&
                                hi <= MAX_INDIRECT) begin
                                dec_nxt.op = OP_LD_INDIRECT;
                                case (hi[2:1])
                                    2'd0: dec_nxt.adjust = ADJ_INC;
                                    2'd1: dec_nxt.adjust = ADJ_DEC;
                                    default: dec_nxt.adjust = ADJ_NONE;
                                endcase
                                if (hi[2:1] != 2'd2 && hi[2:1] != 2'd3) begin
                                    dec_nxt.adjust_step = PTR_STEP;
                                end
                                if (hi[2:1] == 2'd3) begin
                                    dec_nxt.base = hi[0] ? PTR_FOUR : PTR_THREE;
                                end else begin
                                    dec_nxt.base = hi[0] ? PTR_TWO : PTR_ONE;
                                end
                            end
                        end
                        LEAD_DISP: begin
                            if (byte_data[3:0] == LOW_NIB_WORD &&
                                hi <= MAX_DISP) begin
                                dec_nxt.op = OP_LD_DISP;
                                left_nxt = 2'd1;
                                case (hi[2:0])
                                    3'd0: dec_nxt.base = PTR_ONE;
                                    3'd1: dec_nxt.base = PTR_STACK;
                                    3'd2: dec_nxt.base = PTR_TWO;
                                    3'd3: dec_nxt.base = PTR_FOUR;
                                    default: dec_nxt.base = PTR_THREE;
                                endcase
                            end
                        end
                        LEAD_IMM_IDX: begin
                            if (byte_data[3:0] == LOW_NIB_WORD &&
                                hi <= MAX_IMM_IDX) begin
                                dec_nxt.op = OP_LD_IMM_IDX;
                                left_nxt = 2'd3;
                                case (hi[1:0])
                                    2'd0: dec_nxt.index = IDX_PAIR_TWO;
                                    2'd1: dec_nxt.index = IDX_BYTE;
                                    2'd2: dec_nxt.index = IDX_PAIR_THREE;
                                    default: dec_nxt.index = IDX_BYTE_TWO;
                                endcase
                            end
                        end
                        LEAD_BASE_IDX: begin
                            if (byte_data == BASE_IDX_CODE) begin
                                dec_nxt.op = OP_LD_BASE_IDX;
                                dec_nxt.base = PTR_ONE;
                                dec_nxt.index = IDX_BYTE;
                            end
                        end
                        default: dec_nxt.op = OP_NONE;
                    endcase
                    // Ops without operand bytes finish on the second byte
                    if (dec_nxt.op != OP_NONE) begin
                        state_nxt = (left_nxt == 2'd0) ? S_DONE : S_OPERAND;
                    end
                end
                S_OPERAND: begin
                    if (dec_r.op == OP_LD_SHORT_WORD ||
                        dec_r.op == OP_LD_SHORT_LONG ||
                        dec_r.op == OP_LD_DISP) begin
                        dec_nxt.offset = byte_data;
                    end else begin
                        pos = slot(dec_r.op, idx_r);
                        case (pos)
                            5'd0: dec_nxt.address[7:0] = byte_data;
                            5'd8: dec_nxt.address[15:8] = byte_data;
                            5'd16: dec_nxt.address[23:16] = byte_data;
                            default: dec_nxt.offset = dec_r.offset;
                        endcase
                    end
                    idx_nxt = idx_r + 2'd1;
                    left_nxt = left_r - 2'd1;
                    if (left_r == 2'd1) begin
                        state_nxt = S_DONE;
                    end
                end
                default: state_nxt = S_LEAD;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= S_LEAD;
            lead_r <= 8'h00;
            left_r <= 2'd0;
            idx_r <= 2'd0;
            dec_r <= '0;
        end else begin
            state_r <= state_nxt;
            lead_r <= lead_nxt;
            left_r <= left_nxt;
            idx_r <= idx_nxt;
            dec_r <= dec_nxt;
        end
    end

    // decode_valid lasts one cycle, undefined_instr stays high over back-to-back unlisted lead bytes; the held fields stay until the next lead byte
    assign decode_valid = (state_r == S_DONE);
    assign undefined_instr = (state_r == S_UNDEF);
    assign decode = dec_r;
endmodule : word_move_opcode_decoder

// *** verification/word_move_fetch_model.sv ***
// Fetch-unit model that hands instruction bytes to the decoder
`timescale 1ns/1ps
module word_move_fetch_model (
    input wire logic clk,
    output logic byte_valid,
    output logic [7:0] byte_data
);
    initial begin
        byte_valid = 1'b0;
        byte_data = 8'h00;
    end
    // One byte per edge; the decoder never stalls, so no wait is needed
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        byte_valid <= 1'b1;
        byte_data <= b;
    endtask : send
    // Idle data is inverted so a stale byte is never mistaken for a new one
    task automatic stop();
        @(posedge clk);
        byte_valid <= 1'b0;
        byte_data <= ~byte_data;
    endtask : stop
endmodule : word_move_fetch_model

// *** verification/word_move_opcode_decoder_chk.sv ***
// Checker for the word-move opcode decoder
`timescale 1ns/1ps
module word_move_opcode_decoder_chk
    import word_move_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic decode_valid,
    input wire decode_t decode,
    input wire logic undefined_instr
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // A byte is known to be a lead only when taken in a pulse cycle
    sequence lead_two(logic [7:0] b, logic [7:0] m, logic [7:0] v);
        byte_valid && byte_data == b && (decode_valid || undefined_instr)
        ##1 byte_valid && (byte_data & m) == v;
    endsequence
    AST_ABS16: assert property (lead_two(LEAD_ABS, 8'h1f, 8'h09)
        ##1 byte_valid [*2] |=> decode_valid && decode.op == OP_ST_ABS16
        && decode.address[15:0] == {$past(byte_data), $past(byte_data, 2)})
        else $error("abs16 store decoded wrongly");
    AST_LD24: assert property (lead_two(LEAD_ABS, 8'h1f, 8'h0a)
        ##1 byte_valid [*3] |=> decode.op == OP_LD_ABS24 && decode.address
        == {$past(byte_data, 3), $past(byte_data), $past(byte_data, 2)})
        else $error("abs24 load address order wrong");
    AST_ST24_PAIR: assert property (lead_two(LEAD_ABS, 8'h1f, 8'h0b)
        ##1 byte_valid [*3] |=> decode_valid && decode.op == OP_ST_ABS24
        && decode.reg_pair_field == $past(byte_data[7:5], 4))
        else $error("abs24 store or pair field wrong");
    AST_SHORT: assert property (lead_two(LEAD_SHORT, 8'hff, 8'h21)
        ##1 byte_valid |=> decode.op == OP_LD_SHORT_WORD && !decode.alt_area
        && decode.offset == $past(byte_data))
        else $error("short pointer load wrong");
    AST_INC: assert property (lead_two(LEAD_INDIRECT, 8'hff, 8'h01)
        |=> decode_valid && decode.op == OP_LD_INDIRECT
        && decode.base == PTR_ONE && decode.adjust == ADJ_INC
        && decode.adjust_step == PTR_STEP)
        else $error("post-increment load wrong");
    AST_DISP: assert property (lead_two(LEAD_DISP, 8'hff, 8'h11)
        ##1 byte_valid |=> decode.op == OP_LD_DISP
        && decode.base == PTR_STACK && decode.offset == $past(byte_data))
        else $error("displacement load wrong");
    AST_IMM: assert property (lead_two(LEAD_IMM_IDX, 8'hff, 8'h31)
        ##1 byte_valid [*3] |=> decode.index == IDX_BYTE_TWO && decode.address
        == {$past(byte_data), $past(byte_data, 2), $past(byte_data, 3)})
        else $error("immediate offset load wrong");
    AST_BIDX: assert property (lead_two(LEAD_BASE_IDX, 8'hff, 8'h01)
        |=> decode_valid && decode.op == OP_LD_BASE_IDX
        && decode.base == PTR_ONE && decode.index == IDX_BYTE)
        else $error("base plus index load wrong");
    AST_UNDEF: assert property (lead_two(LEAD_INDIRECT, 8'h0f, 8'h08)
        |=> undefined_instr && !decode_valid)
        else $error("unlisted code not flagged");
endmodule : word_move_opcode_decoder_chk
bind word_move_opcode_decoder word_move_opcode_decoder_chk i_chk (
    .clk(clk), .rst(rst), .byte_valid(byte_valid), .byte_data(byte_data),
    .decode_valid(decode_valid), .decode(decode),
    .undefined_instr(undefined_instr));

// *** verification/word_move_opcode_decoder_tb.sv ***
// Testbench for the word-move opcode decoder
`timescale 1ns/1ps
module word_move_opcode_decoder_tb;
    import word_move_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    wire logic byte_valid;
    wire logic [7:0] byte_data;
    logic decode_valid;
    decode_t decode;
    logic undefined_instr;
    int n_mismatch = 0;
    int tests_run = 0;
    sel_t ind_base[8] = '{PTR_ONE, PTR_TWO, PTR_ONE, PTR_TWO,
        PTR_ONE, PTR_TWO, PTR_THREE, PTR_FOUR};
    adj_t ind_adj[8] = '{ADJ_INC, ADJ_INC, ADJ_DEC, ADJ_DEC,
        ADJ_NONE, ADJ_NONE, ADJ_NONE, ADJ_NONE};
    sel_t disp_base[5] = '{PTR_ONE, PTR_STACK, PTR_TWO, PTR_FOUR, PTR_THREE};
    sel_t imm_idx[4] = '{IDX_PAIR_TWO, IDX_BYTE, IDX_PAIR_THREE, IDX_BYTE_TWO};
    logic [15:0] bad[7] = '{16'h1608, 16'h0651, 16'h1702, 16'h0a41, 16'h3c08,
        16'h3e0c, 16'h0722};
    initial forever #4 clk = ~clk;
    word_move_fetch_model i_fetch (.clk(clk), .byte_valid(byte_valid),
        .byte_data(byte_data));
    word_move_opcode_decoder i_dut (.clk(clk), .rst(rst),
        .byte_valid(byte_valid), .byte_data(byte_data),
        .decode_valid(decode_valid), .decode(decode),
        .undefined_instr(undefined_instr));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    // Leading ff forces a pulse so the checker can tell the lead byte
    task automatic feed(input logic [7:0] q[$]);
        i_fetch.send(8'hff);
        foreach (q[i]) i_fetch.send(q[i]);
        i_fetch.stop();
        #1;
    endtask : feed
    task automatic done(input op_t o);
        check(decode_valid, 1'b1);
        check(undefined_instr, 1'b0);
        check(decode.op, o);
    endtask : done
    task automatic t_abs();
        feed('{8'h3e, 8'h29, 8'h34, 8'h12});
        done(OP_ST_ABS16);
        check(decode.reg_pair_field, 3'h1);
        check(decode.address[15:0], 16'h1234);
        feed('{8'h3e, 8'h4a, 8'h56, 8'h78, 8'h9a});
        done(OP_LD_ABS24);
        check(decode.address, 24'h569a78);
        feed('{8'h3e, 8'heb, 8'h01, 8'h02, 8'h03});
        done(OP_ST_ABS24);
        check({decode.reg_pair_field, decode.address}, 27'h7010302);
    endtask : t_abs
    task automatic t_short();
        feed('{8'h07, 8'h21, 8'h5a});
        done(OP_LD_SHORT_WORD);
        check({decode.alt_area, decode.offset}, 9'h05a);
        feed('{8'h3c, 8'h07, 8'h31, 8'ha5});
        done(OP_LD_SHORT_LONG);
        check({decode.alt_area, decode.offset}, 9'h1a5);
    endtask : t_short
    task automatic t_modes();
        for (int n = 0; n < 8; n++) begin
            feed('{8'h16, {n[3:0], 4'h1}});
            done(OP_LD_INDIRECT);
            check(decode.base, ind_base[n]);
            check(decode.adjust, ind_adj[n]);
            check(decode.adjust_step, (n < 4) ? 3'h2 : 3'h0);
        end
        for (int n = 0; n < 5; n++) begin
            feed('{8'h06, {n[3:0], 4'h1}, 8'hc3});
            done(OP_LD_DISP);
            check({decode.base, decode.offset}, {disp_base[n], 8'hc3});
        end
        for (int n = 0; n < 4; n++) begin
            feed('{8'h0a, {n[3:0], 4'h1}, 8'h11, 8'h22, 8'h33});
            done(OP_LD_IMM_IDX);
            check({decode.index, decode.address}, {imm_idx[n], 24'h332211});
        end
    endtask : t_modes
    task automatic t_base_undef();
        feed('{8'h17, 8'h01});
        done(OP_LD_BASE_IDX);
        check({decode.base, decode.index}, {PTR_ONE, IDX_BYTE});
        for (int i = 0; i < 7; i++) begin
            feed('{bad[i][15:8], bad[i][7:0]});
            check({undefined_instr, decode_valid}, 2'b10);
        end
    endtask : t_base_undef
    // Reset in mid-instruction must drop it; then a byte gap must be held
    task automatic t_reset();
        i_fetch.send(8'h3e);
        i_fetch.send(8'h29);
        i_fetch.stop();
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        check({decode_valid, undefined_instr, decode}, '0);
        i_fetch.send(8'hff);
        i_fetch.send(8'h3e);
        i_fetch.send(8'h29);
        i_fetch.stop();
        i_fetch.send(8'h34);
        i_fetch.send(8'h12);
        i_fetch.stop();
        #1;
        done(OP_ST_ABS16);
        check(decode.address[15:0], 16'h1234);
    endtask : t_reset
    task automatic conclude();
        $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        check({decode_valid, decode.op}, {1'b0, OP_NONE});
        t_abs();
        t_short();
        t_modes();
        t_base_undef();
        t_reset();
        conclude();
    end
    // Whole run needs well under 400 cycles; this leaves wide margin
    initial begin
        #50000;
        n_mismatch++;
        conclude();
    end
endmodule : word_move_opcode_decoder_tb
